// ===== core/atm_defs.svh
// default sizes and reset values for the axi transaction monitor
// assumes inclusion by the monitor package and the monitor core
`ifndef ATM_DEFS_SVH
`define ATM_DEFS_SVH
`define ATM_ID_W 4
`define ATM_ADDR_W 32
`define ATM_TIME_W 32
`define ATM_NSLOT_DEF 2
`define ATM_NCNT_DEF 4
`define ATM_DEPTH_DEF 4
`define ATM_TIME_RST 32'h0000_0000
`endif

// ===== core/atm_pkg.sv
// types shared by the axi transaction monitor
// assumes atm_defs.svh sits beside it
`include "atm_defs.svh"
package atm_pkg;
    localparam int ATM_ID_W = `ATM_ID_W;
    localparam int ATM_ADDR_W = `ATM_ADDR_W;
    localparam int ATM_TIME_W = `ATM_TIME_W;

    // control and tag signals of one probed interface
    typedef struct packed {
        logic arvalid;
        logic arready;
        logic [ATM_ID_W-1:0] arid;
        logic [ATM_ADDR_W-1:0] araddr;
        logic rvalid;
        logic rready;
        logic rlast;
        logic [ATM_ID_W-1:0] rid;
        logic awvalid;
        logic awready;
        logic [ATM_ID_W-1:0] awid;
        logic [ATM_ADDR_W-1:0] awaddr;
        logic bvalid;
        logic bready;
        logic [ATM_ID_W-1:0] bid;
    } atm_axi_type;

    // address command channel event
    typedef enum logic [1:0] {
        ATM_CMD_IDLE = 2'h0,
        ATM_CMD_BUSY = 2'h1,
        ATM_CMD_END = 2'h3
    } atm_cmd_type;

    // data or response channel event
    typedef enum logic [1:0] {
        ATM_BEAT_IDLE = 2'h0,
        ATM_BEAT_MID = 2'h1,
        ATM_BEAT_LAST = 2'h3
    } atm_beat_type;

    // per slot channel events
    typedef struct packed {
        atm_cmd_type ar;
        atm_beat_type r;
        atm_cmd_type aw;
        atm_beat_type b;
    } atm_evt_type;

    // one finished transaction
    typedef struct packed {
        logic vld;
        logic wr;
        logic [ATM_ID_W-1:0] id;
        logic [ATM_ADDR_W-1:0] addr;
        logic [ATM_TIME_W-1:0] t_start;
        logic [ATM_TIME_W-1:0] t_end;
        logic [ATM_TIME_W-1:0] dur;
    } atm_rpt_type;
endpackage

// ===== core/atm_monitor.sv
// axi transaction monitor: outstanding tracker and per slot monitor top
// assumes all probed interfaces run on mclk, the monitored interface clock
`timescale 1ns/1ps
`default_nettype none
`include "atm_defs.svh"

// ****************************************
// outstanding transaction tracker
// ****************************************
module atm_tracker
    import atm_pkg::*;
#(
    parameter int NCNT = `ATM_NCNT_DEF,
    parameter int DEPTH = `ATM_DEPTH_DEF,
    parameter bit WR = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    // start of transaction
    input wire logic s_evt,
    input wire logic [ATM_ID_W-1:0] s_id,
    input wire logic [ATM_ADDR_W-1:0] s_addr,
    input wire logic [ATM_TIME_W-1:0] s_time,
    input wire logic s_win,
    // end of transaction
    input wire logic e_evt,
    input wire logic [ATM_ID_W-1:0] e_id,
    input wire logic [ATM_TIME_W-1:0] now,
    input wire logic win,
    // results
    output atm_rpt_type rpt,
    output logic ovf_id,
    output logic ovf_tab
);
    localparam int IW = (NCNT > 1) ? $clog2(NCNT) : 1;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic ent_vld [NCNT];
    logic [ATM_ID_W-1:0] ent_id [NCNT];
    logic [CW-1:0] cnt [NCNT];
    logic [PW-1:0] wp [NCNT];
    logic [PW-1:0] rp [NCNT];
    logic [ATM_ADDR_W-1:0] q_addr [NCNT][DEPTH];
    logic [ATM_TIME_W-1:0] q_time [NCNT][DEPTH];
    logic q_win [NCNT][DEPTH];
    logic [NCNT-1:0] hit_s;
    logic [NCNT-1:0] hit_e;
    logic [NCNT-1:0] free;
    int s_idx;
    int e_idx;
    logic s_room;
    logic [IW-1:0] s_sel;
    logic [IW-1:0] e_sel;

    // lowest set bit, NCNT when none
    function automatic int first_set(input logic [NCNT-1:0] v);
        int r;
        r = NCNT;
        for (int i = NCNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i;
            end
        end
        return r;
    endfunction

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCNT; g++) begin : g_match
            assign hit_s[g] = ent_vld[g] && (ent_id[g] == s_id);
            assign hit_e[g] = ent_vld[g] && (ent_id[g] == e_id);
            assign free[g] = !ent_vld[g];
        end
    endgenerate

    always_comb begin
        e_idx = first_set(hit_e);
        s_idx = (|hit_s) ? first_set(hit_s) : first_set(free);
        s_sel = IW'(s_idx);
        e_sel = IW'(e_idx);
        s_room = 1'b0;
        if (s_idx < NCNT) begin
            s_room = (cnt[s_sel] != CW'(DEPTH)) || (e_evt && (e_idx == s_idx));
        end
    end

    generate
        for (g = 0; g < NCNT; g++) begin : g_ent
            logic take_s;
            logic take_e;
            logic [CW-1:0] next_cnt;
            assign take_s = s_evt && s_room && (s_idx == g);
            assign take_e = e_evt && (e_idx == g);
            assign next_cnt = cnt[g] + CW'(take_s) - CW'(take_e);

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    ent_vld[g] <= 1'b0;
                    ent_id[g] <= '0;
                    cnt[g] <= '0;
                    wp[g] <= '0;
                    rp[g] <= '0;
                end else if (clear) begin
                    ent_vld[g] <= 1'b0;
                    cnt[g] <= '0;
                    wp[g] <= '0;
                    rp[g] <= '0;
                end else begin
                    cnt[g] <= next_cnt;
                    ent_vld[g] <= (next_cnt != '0);
                    if (take_s) begin
                        ent_id[g] <= s_id;
                        wp[g] <= ptr_inc(wp[g]);
                    end
                    if (take_e) begin
                        rp[g] <= ptr_inc(rp[g]);
                    end
                end
            end

            // start records kept in order per id
            always_ff @(posedge mclk) begin
                if (take_s) begin
                    q_addr[g][wp[g]] <= s_addr;
                    q_time[g][wp[g]] <= s_time;
                    q_win[g][wp[g]] <= s_win;
                end
            end
        end
    endgenerate

    // finished transaction report
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rpt <= '0;
        end else begin
            rpt.vld <= 1'b0;
            if (e_evt && (e_idx < NCNT) && !clear) begin
                rpt.vld <= q_win[e_sel][rp[e_sel]] && win;
                rpt.wr <= WR;
                rpt.id <= e_id;
                rpt.addr <= q_addr[e_sel][rp[e_sel]];
                rpt.t_start <= q_time[e_sel][rp[e_sel]];
                rpt.t_end <= now;
                rpt.dur <= now - q_time[e_sel][rp[e_sel]];
            end
        end
    end

    // sticky overflow flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_id <= 1'b0;
            ovf_tab <= 1'b0;
        end else if (clear) begin
            ovf_id <= 1'b0;
            ovf_tab <= 1'b0;
        end else begin
            if (s_evt && (s_idx < NCNT) && !s_room) begin
                ovf_id <= 1'b1;
            end
            if (s_evt && (s_idx >= NCNT)) begin
                ovf_tab <= 1'b1;
            end
        end
    end
endmodule

module atm_monitor
    import atm_pkg::*;
#(
    parameter int NSLOT = `ATM_NSLOT_DEF,
    parameter int NCNT = `ATM_NCNT_DEF,
    parameter int DEPTH = `ATM_DEPTH_DEF,
    parameter logic [NSLOT-1:0] LITE = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    // capture window
    input wire logic win,
    // probed interfaces
    input wire atm_axi_type axi [NSLOT],
    // channel events
    output atm_evt_type evt [NSLOT],
    // finished transactions
    output atm_rpt_type rd_rpt [NSLOT],
    output atm_rpt_type wr_rpt [NSLOT],
    // overflow flags
    output logic [NSLOT-1:0] rd_ovf_id,
    output logic [NSLOT-1:0] rd_ovf_tab,
    output logic [NSLOT-1:0] wr_ovf_id,
    output logic [NSLOT-1:0] wr_ovf_tab,
    // time stamp
    output logic [ATM_TIME_W-1:0] now
);
    // ****************************************
    // time stamp
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            now <= `ATM_TIME_RST;
        end else begin
            now <= now + ATM_TIME_W'(1);
        end
    end

    // ****************************************
    // slots
    // ****************************************
    genvar s;
    generate
        for (s = 0; s < NSLOT; s++) begin : g_slot
            atm_axi_type a;
            logic ar_busy;
            logic aw_busy;
            logic [ATM_TIME_W-1:0] ar_t;
            logic [ATM_TIME_W-1:0] aw_t;
            logic ar_w;
            logic aw_w;
            logic ar_go;
            logic r_end;
            logic aw_go;
            logic b_end;

            // lite interfaces carry no id and one beat per read
            always_comb begin
                a = axi[s];
                if (LITE[s]) begin
                    a.arid = '0;
                    a.rid = '0;
                    a.awid = '0;
                    a.bid = '0;
                    a.rlast = 1'b1;
                end
            end

            assign ar_go = a.arvalid && a.arready;
            assign r_end = a.rvalid && a.rready && a.rlast;
            assign aw_go = a.awvalid && a.awready;
            assign b_end = a.bvalid && a.bready;

            // first cycle of a command holds its start time
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    ar_busy <= 1'b0;
                    aw_busy <= 1'b0;
                    ar_t <= `ATM_TIME_RST;
                    aw_t <= `ATM_TIME_RST;
                    ar_w <= 1'b0;
                    aw_w <= 1'b0;
                end else begin
                    ar_busy <= a.arvalid && !a.arready;
                    aw_busy <= a.awvalid && !a.awready;
                    if (a.arvalid && !ar_busy) begin
                        ar_t <= now;
                        ar_w <= win;
                    end
                    if (a.awvalid && !aw_busy) begin
                        aw_t <= now;
                        aw_w <= win;
                    end
                end
            end

            // channel event outputs
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    evt[s] <= '{ATM_CMD_IDLE, ATM_BEAT_IDLE, ATM_CMD_IDLE, ATM_BEAT_IDLE};
                end else begin
                    evt[s].ar <= ar_go ? ATM_CMD_END :
                                 a.arvalid ? ATM_CMD_BUSY : ATM_CMD_IDLE;
                    evt[s].r <= r_end ? ATM_BEAT_LAST :
                                (a.rvalid && a.rready) ? ATM_BEAT_MID : ATM_BEAT_IDLE;
                    evt[s].aw <= aw_go ? ATM_CMD_END :
                                 a.awvalid ? ATM_CMD_BUSY : ATM_CMD_IDLE;
                    evt[s].b <= b_end ? ATM_BEAT_LAST : ATM_BEAT_IDLE;
                end
            end

            // read and write trackers, capacity set by NCNT and DEPTH
            atm_tracker #(.NCNT(NCNT), .DEPTH(DEPTH), .WR(1'b0)) u_rd (
                .mclk(mclk),
                .rst_n(rst_n),
                .clear(clear),
                .s_evt(ar_go),
                .s_id(a.arid),
                .s_addr(a.araddr),
                .s_time(ar_busy ? ar_t : now),
                .s_win(ar_busy ? ar_w : win),
                .e_evt(r_end),
                .e_id(a.rid),
                .now(now),
                .win(win),
                .rpt(rd_rpt[s]),
                .ovf_id(rd_ovf_id[s]),
                .ovf_tab(rd_ovf_tab[s])
            );

            atm_tracker #(.NCNT(NCNT), .DEPTH(DEPTH), .WR(1'b1)) u_wr (
                .mclk(mclk),
                .rst_n(rst_n),
                .clear(clear),
                .s_evt(aw_go),
                .s_id(a.awid),
                .s_addr(a.awaddr),
                .s_time(aw_busy ? aw_t : now),
                .s_win(aw_busy ? aw_w : win),
                .e_evt(b_end),
                .e_id(a.bid),
                .now(now),
                .win(win),
                .rpt(wr_rpt[s]),
                .ovf_id(wr_ovf_id[s]),
                .ovf_tab(wr_ovf_tab[s])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ===== test/atm_chk.sv
// checker of slot 0 channel events, read reports and clear
// assumes binding to atm_monitor, all on mclk
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module atm_chk
    import atm_pkg::*;
#(
    parameter int NSLOT = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    // watched ports
    input wire atm_axi_type axi [NSLOT],
    input wire atm_evt_type evt [NSLOT],
    input wire atm_rpt_type rd_rpt [NSLOT],
    input wire logic [NSLOT-1:0] rd_ovf_id
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_ar_busy: assert property (axi[0].arvalid && !axi[0].arready |=> evt[0].ar == ATM_CMD_BUSY)
        else $error("ar busy missed");
    chk_ar_end: assert property (axi[0].arvalid && axi[0].arready |=> evt[0].ar == ATM_CMD_END)
        else $error("ar end missed");
    chk_r_last: assert property (axi[0].rvalid && axi[0].rready && axi[0].rlast |=> evt[0].r == ATM_BEAT_LAST)
        else $error("r last missed");
    chk_r_idle: assert property (!(axi[0].rvalid && axi[0].rready) |=> evt[0].r == ATM_BEAT_IDLE)
        else $error("r idle missed");
    chk_aw_end: assert property (axi[0].awvalid && axi[0].awready |=> evt[0].aw == ATM_CMD_END)
        else $error("aw end missed");
    chk_b_resp: assert property (axi[0].bvalid && axi[0].bready |=> evt[0].b == ATM_BEAT_LAST)
        else $error("b response missed");
    chk_rd_pair: assert property (rd_rpt[0].vld |-> $past(axi[0].rvalid && axi[0].rready && axi[0].rlast) && $past(axi[0].rid) == rd_rpt[0].id)
        else $error("read report without matching end");
    chk_clear_flag: assert property (clear |=> rd_ovf_id == '0)
        else $error("flag kept over clear");
endmodule
bind atm_monitor atm_chk #(.NSLOT(NSLOT)) i_atm_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(clear),
    .axi(axi),
    .evt(evt),
    .rd_rpt(rd_rpt),
    .rd_ovf_id(rd_ovf_id)
);
`default_nettype wire

// ===== test/atm_axi_slave.sv
// axi slave model: random ready, in order read and write responses
// assumes the bench drives the master fields of mi
`timescale 1ns/1ps
`default_nettype none
// ****
// slave model
// ****
module atm_axi_slave
    import atm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic hold,
    input wire logic [1:0] stall,
    // bus
    input wire atm_axi_type mi,
    output var atm_axi_type so
);
    logic [ATM_ID_W-1:0] rq [$];
    logic [ATM_ID_W-1:0] bq [$];
    logic beat, v, w;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            so <= '0;
            rq.delete();
            bq.delete();
            beat = 1'b0;
        end else begin
            if (so.rvalid && mi.rready) begin
                if (beat) void'(rq.pop_front());
                beat = !beat;
            end
            if (so.bvalid && mi.bready) void'(bq.pop_front());
            if (mi.arvalid && so.arready) rq.push_back(mi.arid);
            if (mi.awvalid && so.awready) bq.push_back(mi.awid);
            v = (so.rvalid && !mi.rready) || (!hold && rq.size() > 0);
            w = (so.bvalid && !mi.bready) || (!hold && bq.size() > 0);
            so.arready <= mi.arvalid && !so.arready && !stall[0];
            so.awready <= mi.awvalid && !so.awready && !stall[1];
            so.rvalid <= v;
            so.rlast <= v ? beat : !so.rlast;
            so.rid <= v ? rq[0] : ~so.rid;
            so.bvalid <= w;
            so.bid <= w ? bq[0] : ~so.bid;
        end
    end
endmodule
`default_nettype wire

// ===== test/atm_monitor_tb.sv
// bench of the axi transaction monitor with a queue model
// assumes atm_pkg, atm_monitor, atm_chk and atm_axi_slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
// ****
// bench
// ****
module atm_monitor_tb
    import atm_pkg::*;
;
    localparam int NCNT = 2;
    localparam int DEPTH = 2;
    localparam logic [1:0] LITE = 2'h2;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic clear = 1'b0;
    logic win = 1'b0;
    logic [1:0] hold = 2'h0;
    logic [31:0] rn = 32'h0000_fb63;
    logic [31:0] cyc, now;
    int errors = 0;
    int samples_checked = 0;
    atm_axi_type m [2] = '{default: '0};
    atm_axi_type p [2], axi [2];
    atm_evt_type evt [2], xe [2];
    atm_rpt_type rd_rpt [2], wr_rpt [2], xr [2][2];
    logic [1:0] rd_ovf_id, rd_ovf_tab, wr_ovf_id, wr_ovf_tab;
    logic [64:0] q [2][2][16][$];
    logic bz [2][2], pw [2][2], xo [2][2], xt [2][2];
    logic [31:0] pt [2][2];
    always #10 mclk = ~mclk;
    always_comb for (int s = 0; s < 2; s++) axi[s] = m[s] | p[s];
    atm_monitor #(.NSLOT(2), .NCNT(NCNT), .DEPTH(DEPTH), .LITE(LITE)) i_atm_monitor (
        .mclk(mclk), .rst_n(rst_n), .clear(clear), .win(win), .axi(axi), .evt(evt), .rd_rpt(rd_rpt),
        .wr_rpt(wr_rpt), .rd_ovf_id(rd_ovf_id), .rd_ovf_tab(rd_ovf_tab), .wr_ovf_id(wr_ovf_id),
        .wr_ovf_tab(wr_ovf_tab), .now(now));
    for (genvar s = 0; s < 2; s++) begin : g_slv
        atm_axi_slave i_atm_axi_slave (.mclk(mclk), .rst_n(rst_n), .hold(hold[s]), .stall(rn[2*s+1:2*s]),
            .mi(m[s]), .so(p[s]));
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    always @(posedge mclk) begin
        rn <= xs(rn);
        win <= rn[8] | rn[9];
        for (int s = 0; s < 2; s++) begin
            m[s].rready <= rn[4+s] | rn[6+s];
            m[s].bready <= rn[10+s] | rn[12+s];
        end
    end
    always @(posedge mclk or negedge rst_n) cyc <= !rst_n ? 32'h0000_0000 : cyc + 32'h0000_0001;
    // reference model, compared at every negedge while rst_n is high
    always @(negedge mclk) begin
        logic v, r, en;
        logic [3:0] id, eid;
        logic [31:0] a;
        logic [64:0] e;
        atm_rpt_type dr;
        int n, h;
        if (rst_n) `CHK(now, cyc)
        for (int s = 0; s < 2; s++) begin
            if (rst_n) `CHK(evt[s], xe[s])
            xe[s].ar = axi[s].arvalid ? (axi[s].arready ? ATM_CMD_END : ATM_CMD_BUSY) : ATM_CMD_IDLE;
            xe[s].aw = axi[s].awvalid ? (axi[s].awready ? ATM_CMD_END : ATM_CMD_BUSY) : ATM_CMD_IDLE;
            xe[s].r = !(axi[s].rvalid && axi[s].rready) ? ATM_BEAT_IDLE :
                      (axi[s].rlast || LITE[s]) ? ATM_BEAT_LAST : ATM_BEAT_MID;
            xe[s].b = axi[s].bvalid && axi[s].bready ? ATM_BEAT_LAST : ATM_BEAT_IDLE;
            for (int d = 0; d < 2; d++) begin
                v = d ? axi[s].awvalid : axi[s].arvalid;
                r = d ? axi[s].awready : axi[s].arready;
                id = LITE[s] ? 4'h0 : d ? axi[s].awid : axi[s].arid;
                a = d ? axi[s].awaddr : axi[s].araddr;
                en = d ? axi[s].bvalid && axi[s].bready : axi[s].rvalid && axi[s].rready && (axi[s].rlast || LITE[s]);
                eid = LITE[s] ? 4'h0 : d ? axi[s].bid : axi[s].rid;
                dr = d ? wr_rpt[s] : rd_rpt[s];
                if (rst_n) begin
                    if (xr[s][d].vld) `CHK(dr, xr[s][d])
                    else `CHK(dr.vld, 1'b0)
                    `CHK(d ? wr_ovf_id[s] : rd_ovf_id[s], xo[s][d])
                    `CHK(d ? wr_ovf_tab[s] : rd_ovf_tab[s], xt[s][d])
                end
                if (v && !bz[s][d]) begin
                    pt[s][d] = cyc;
                    pw[s][d] = win;
                end
                bz[s][d] = rst_n && v && !r;
                xr[s][d] = '0;
                if (!rst_n || clear) begin
                    xo[s][d] = 1'b0;
                    xt[s][d] = 1'b0;
                    for (int i = 0; i < 16; i++) q[s][d][i].delete();
                end else begin
                    n = 0;
                    for (int i = 0; i < 16; i++) n += q[s][d][i].size() > 0;
                    h = q[s][d][id].size();
                    if (en && q[s][d][eid].size() > 0) begin
                        e = q[s][d][eid].pop_front();
                        xr[s][d] = '{e[64] && win, d[0], eid, e[63:32], e[31:0], cyc, cyc - e[31:0]};
                    end
                    if (v && r) begin
                        if (q[s][d][id].size() == DEPTH) xo[s][d] = 1'b1;
                        else if (h == 0 && n == NCNT) xt[s][d] = 1'b1;
                        else q[s][d][id].push_back({pw[s][d], a, pt[s][d]});
                    end
                end
            end
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmd(input int s, input int d, input logic [3:0] id, input logic [31:0] a);
        int k;
        @(posedge mclk);
        if (d) {m[s].awvalid, m[s].awid, m[s].awaddr} <= {1'b1, id, a};
        else {m[s].arvalid, m[s].arid, m[s].araddr} <= {1'b1, id, a};
        for (k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (d ? axi[s].awready : axi[s].arready) break;
        end
        if (k == 40) begin
            errors++;
            results();
        end
        if (d) {m[s].awvalid, m[s].awid, m[s].awaddr} <= {1'b0, ~id, ~a};
        else {m[s].arvalid, m[s].arid, m[s].araddr} <= {1'b0, ~id, ~a};
    endtask
    task automatic pulse_clear();
        @(posedge mclk);
        clear <= 1'b1;
        @(posedge mclk);
        clear <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 60; i++) cmd(rn[0], rn[1], {3'h0, rn[2]}, rn);
        repeat (30) @(posedge mclk);
        $display("test traffic done");
        pulse_clear();
        hold <= 2'h1;
        for (int d = 0; d < 2; d++) begin
            foreach (q[0][0][i]) ;
            cmd(0, d, 4'h5, 32'h0000_1000);
            cmd(0, d, 4'h5, 32'h0000_1004);
            cmd(0, d, 4'h5, 32'h0000_1008);
            cmd(0, d, 4'h6, 32'h0000_2000);
            cmd(0, d, 4'h7, 32'h0000_3000);
        end
        hold <= 2'h0;
        repeat (40) @(posedge mclk);
        pulse_clear();
        $display("test overflow done");
        hold <= 2'h1;
        cmd(0, 0, 4'h3, 32'h0000_4000);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        hold <= 2'h0;
        cmd(0, 1, 4'h2, 32'h0000_5000);
        repeat (30) @(posedge mclk);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
